/* rtl/lcc_pkg.sv */
package lcc_pkg;
   // Register byte addresses
   localparam logic [31:0] LCC_CTRL_ADDR  = 32'h4000_0000;
   localparam logic [31:0] LCC_RXPTR_ADDR = 32'h4000_0040;
   // Control register field positions
   localparam int LCC_SCAN_ABORT_BIT = 24;
   localparam int LCC_MD_BYP_BIT     = 22;
   localparam int LCC_SN_BYP_BIT     = 21;
   localparam int LCC_NESN_BYP_BIT   = 20;
   localparam int LCC_CRYPTO_BYP_BIT = 19;
   localparam int LCC_WHIT_BYP_BIT   = 18;
   localparam int LCC_CRC_BYP_BIT    = 17;
   localparam int LCC_HOP_BYP_BIT    = 16;
   localparam int LCC_WINOFF_SRC_BIT = 12;
   localparam int LCC_RXPTR_SRC_BIT  = 11;
   localparam int LCC_ADV_FILT_BIT   = 10;
   localparam int LCC_COEX_EN_BIT    = 9;
   localparam int LCC_PREFETCH_BIT   = 8;
   localparam int LCC_RX_WIN_LSB     = 4;
   localparam int LCC_RX_WIN_W       = 4;
   localparam int LCC_SYNC_LIM_LSB   = 0;
   localparam int LCC_SYNC_LIM_W     = 3;
   // Reset values
   localparam logic [31:0] LCC_CTRL_RESET  = 32'h0000_0000;
   localparam logic [31:0] LCC_RXPTR_RESET = 32'h0000_0000;
   // Avalon response codes
   localparam logic [1:0] LCC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] LCC_RESP_DECERR = 2'h3;
endpackage

/* rtl/lcc_bypass_mux.sv */
`timescale 1ns/1ns
`default_nettype none
// Registered two-way select between hardware and software values
module lcc_bypass_mux #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         resetn_in,
   input  wire logic         sel_sw_in,
   input  wire logic [W-1:0] hw_in,
   input  wire logic [W-1:0] sw_in,
   output logic      [W-1:0] out_out
);
   typedef struct packed {
      logic [W-1:0] val;
   } lcc_mux_s;

   lcc_mux_s st_reg;
   lcc_mux_s st_next;

   if (W < 1) begin : g_chk
      $error("lcc_bypass_mux: W must be at least 1");
   end

   // Pick the source
   always_comb begin
      st_next     = st_reg;
      st_next.val = sel_sw_in ? sw_in : hw_in;
   end

   // State register
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign out_out = st_reg.val;
endmodule
`default_nettype wire

/* rtl/lcc_action_bit.sv */
`timescale 1ns/1ns
`default_nettype none
// Write-one action bit that returns to zero when the action is done
module lcc_action_bit (
   input  wire logic clk_in,
   input  wire logic resetn_in,
   input  wire logic set_in,
   input  wire logic done_in,
   output logic      pending_out
);
   typedef struct packed {
      logic pending;
   } lcc_act_s;

   lcc_act_s st_reg;
   lcc_act_s st_next;

   // A new request wins over a done in the same cycle
   always_comb begin
      st_next = st_reg;
      if (set_in) begin
         st_next.pending = 1'b1;
      end else if (done_in) begin
         st_next.pending = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pending_out = st_reg.pending;
endmodule
`default_nettype wire

/* rtl/lcc_core.sv */
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Writing one to scan abort ends the scan window; bit clears when done.
// - More-data bypass set gives exactly one exchange per event.
// - Sequence bypass set sends that field straight from the Tx descriptor.
// - Sequence bypass set ignores received field and reports no sequence error.
// - Crypto bypass set disables payload encryption and decryption.
// - Encryption enabled with crypto bypass still makes the MIC, plain payload.
// - Whitening bypass set turns data whitening off.
// - CRC bypass keeps received CRC, transmits zeros as CRC; else CRC stripped.
// - Hop remap bypass set disables channel remapping.
// - Initiator only: window offset from Tx buffer or event controller.
// - Rx descriptor pointer from control structure or current pointer register.
// - Advertising filter set reports only error-free advertising packets.
// - Coexistence enable gates the WLAN sync pulse.
// - Core enable bit enables exchange-table prefetch.
// - Four-bit default receive window in microseconds.
// - Three-bit limit on sync word bit errors.
module lcc_core #(
   parameter int PTR_W = 15,
   parameter int WOF_W = 16,
   parameter int CRC_W = 24
) (
   input  wire logic              clk_in,
   input  wire logic              resetn_in,
   // Avalon-MM slave
   input  wire logic [31:0]       avs_address_in,
   input  wire logic              avs_read_in,
   input  wire logic              avs_write_in,
   input  wire logic [31:0]       avs_writedata_in,
   input  wire logic [3:0]        avs_byteenable_in,
   output logic      [31:0]       avs_readdata_out,
   output logic      [1:0]        avs_response_out,
   output logic                   avs_waitrequest_out,
   // Scan abort handshake
   input  wire logic              scan_done_in,
   output logic                   scan_abort_req_out,
   // More-data handling
   input  wire logic              more_data_in,
   output logic                   next_exchange_out,
   // Sequence numbering
   input  wire logic              hw_sn_in,
   input  wire logic              desc_sn_in,
   input  wire logic              hw_nesn_in,
   input  wire logic              desc_nesn_in,
   input  wire logic              rx_sn_err_in,
   input  wire logic              rx_nesn_err_in,
   output logic                   tx_sn_out,
   output logic                   tx_nesn_out,
   output logic                   rx_sn_err_out,
   output logic                   rx_nesn_err_out,
   // Encryption
   input  wire logic              conn_encrypt_enable_in,
   output logic                   payload_encrypt_out,
   output logic                   mic_generate_out,
   // Whitening and hopping
   output logic                   whitening_enable_out,
   output logic                   hop_remap_enable_out,
   // CRC handling
   input  wire logic [CRC_W-1:0]  tx_crc_in,
   output logic      [CRC_W-1:0]  tx_crc_out,
   output logic                   rx_crc_strip_out,
   // Window offset
   input  wire logic              initiator_mode_in,
   input  wire logic [WOF_W-1:0]  buf_winoff_in,
   input  wire logic [WOF_W-1:0]  evt_winoff_in,
   output logic      [WOF_W-1:0]  winoff_out,
   // Rx descriptor pointer
   input  wire logic [PTR_W-1:0]  cs_rx_ptr_in,
   output logic      [PTR_W-1:0]  rx_ptr_out,
   // Advertising error filter
   input  wire logic              rx_pkt_done_in,
   input  wire logic              rx_adv_chan_in,
   input  wire logic              rx_pkt_err_in,
   output logic                   rx_pkt_report_out,
   // Coexistence sync pulse
   input  wire logic              coex_sync_in,
   output logic                   coex_sync_out,
   // Static settings
   output logic                   core_prefetch_enable_out,
   output logic      [3:0]        default_rx_window_out,
   output logic      [2:0]        sync_word_error_limit_out
);
   typedef struct packed {
      logic             ack;
      logic [31:0]      rdata;
      logic [1:0]       resp;
      logic             md_byp;
      logic             sn_byp;
      logic             nesn_byp;
      logic             crypto_byp;
      logic             whit_byp;
      logic             crc_byp;
      logic             hop_byp;
      logic             winoff_src;
      logic             rxptr_src;
      logic             adv_filt;
      logic             coex_en;
      logic             prefetch;
      logic [3:0]       rx_win;
      logic [2:0]       sync_lim;
      logic [PTR_W-1:0] cur_ptr;
   } lcc_core_s;

   lcc_core_s st_reg;
   lcc_core_s st_next;

   logic        req;
   logic        hit_ctrl;
   logic        hit_ptr;
   logic        wr_take;
   logic [31:0] be_mask;
   logic [31:0] ctrl_word;
   logic [31:0] ptr_word;
   logic [31:0] ctrl_new;
   logic [31:0] ptr_new;
   logic        scan_pending;
   logic        wof_sel_evt;

   if (PTR_W < 1 || PTR_W > 32) begin : g_chk_ptr
      $error("lcc_core: PTR_W must be 1 to 32");
   end
   if (WOF_W < 1 || CRC_W < 1) begin : g_chk_w
      $error("lcc_core: WOF_W and CRC_W must be at least 1");
   end

   // Bus decode and wait-state handshake
   assign req      = avs_read_in | avs_write_in;
   assign hit_ctrl = (avs_address_in == lcc_pkg::LCC_CTRL_ADDR);
   assign hit_ptr  = (avs_address_in == lcc_pkg::LCC_RXPTR_ADDR);
   assign wr_take  = avs_write_in & st_reg.ack;
   assign avs_waitrequest_out = req & ~st_reg.ack;
   assign avs_readdata_out    = st_reg.rdata;
   assign avs_response_out    = st_reg.resp;

   // Byte lane mask
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         be_mask[i*8 +: 8] = {8{avs_byteenable_in[i]}};
      end
   end

   // Control word as read back; reserved bits zero
   always_comb begin
      ctrl_word = '0;
      ctrl_word[lcc_pkg::LCC_SCAN_ABORT_BIT] = scan_pending;
      ctrl_word[lcc_pkg::LCC_MD_BYP_BIT]     = st_reg.md_byp;
      ctrl_word[lcc_pkg::LCC_SN_BYP_BIT]     = st_reg.sn_byp;
      ctrl_word[lcc_pkg::LCC_NESN_BYP_BIT]   = st_reg.nesn_byp;
      ctrl_word[lcc_pkg::LCC_CRYPTO_BYP_BIT] = st_reg.crypto_byp;
      ctrl_word[lcc_pkg::LCC_WHIT_BYP_BIT]   = st_reg.whit_byp;
      ctrl_word[lcc_pkg::LCC_CRC_BYP_BIT]    = st_reg.crc_byp;
      ctrl_word[lcc_pkg::LCC_HOP_BYP_BIT]    = st_reg.hop_byp;
      ctrl_word[lcc_pkg::LCC_WINOFF_SRC_BIT] = st_reg.winoff_src;
      ctrl_word[lcc_pkg::LCC_RXPTR_SRC_BIT]  = st_reg.rxptr_src;
      ctrl_word[lcc_pkg::LCC_ADV_FILT_BIT]   = st_reg.adv_filt;
      ctrl_word[lcc_pkg::LCC_COEX_EN_BIT]    = st_reg.coex_en;
      ctrl_word[lcc_pkg::LCC_PREFETCH_BIT]   = st_reg.prefetch;
      ctrl_word[lcc_pkg::LCC_RX_WIN_LSB +: lcc_pkg::LCC_RX_WIN_W] = st_reg.rx_win;
      ctrl_word[lcc_pkg::LCC_SYNC_LIM_LSB +: lcc_pkg::LCC_SYNC_LIM_W] = st_reg.sync_lim;
   end

   // Pointer register as read back
   always_comb begin
      ptr_word = '0;
      ptr_word[PTR_W-1:0] = st_reg.cur_ptr;
   end

   // Merged write values per byte lane
   assign ctrl_new = (ctrl_word & ~be_mask) | (avs_writedata_in & be_mask);
   assign ptr_new  = (ptr_word & ~be_mask) | (avs_writedata_in & be_mask);

   // Register file and bus answer
   always_comb begin
      st_next     = st_reg;
      st_next.ack = req & ~st_reg.ack;
      // Capture read data during the wait state
      if (req && !st_reg.ack) begin
         st_next.resp  = (hit_ctrl | hit_ptr) ? lcc_pkg::LCC_RESP_OKAY
                                              : lcc_pkg::LCC_RESP_DECERR;
         st_next.rdata = '0;
         if (avs_read_in && hit_ctrl) begin
            st_next.rdata = ctrl_word;
         end else if (avs_read_in && hit_ptr) begin
            st_next.rdata = ptr_word;
         end
      end
      // Writes land on the edge that ends the waitrequest-low cycle, one after the wait; reserved bits dropped
      if (wr_take && hit_ctrl) begin
         st_next.md_byp     = ctrl_new[lcc_pkg::LCC_MD_BYP_BIT];
         st_next.sn_byp     = ctrl_new[lcc_pkg::LCC_SN_BYP_BIT];
         st_next.nesn_byp   = ctrl_new[lcc_pkg::LCC_NESN_BYP_BIT];
         st_next.crypto_byp = ctrl_new[lcc_pkg::LCC_CRYPTO_BYP_BIT];
         st_next.whit_byp   = ctrl_new[lcc_pkg::LCC_WHIT_BYP_BIT];
         st_next.crc_byp    = ctrl_new[lcc_pkg::LCC_CRC_BYP_BIT];
         st_next.hop_byp    = ctrl_new[lcc_pkg::LCC_HOP_BYP_BIT];
         st_next.winoff_src = ctrl_new[lcc_pkg::LCC_WINOFF_SRC_BIT];
         st_next.rxptr_src  = ctrl_new[lcc_pkg::LCC_RXPTR_SRC_BIT];
         st_next.adv_filt   = ctrl_new[lcc_pkg::LCC_ADV_FILT_BIT];
         st_next.coex_en    = ctrl_new[lcc_pkg::LCC_COEX_EN_BIT];
         st_next.prefetch   = ctrl_new[lcc_pkg::LCC_PREFETCH_BIT];
         st_next.rx_win     =
            ctrl_new[lcc_pkg::LCC_RX_WIN_LSB +: lcc_pkg::LCC_RX_WIN_W];
         st_next.sync_lim   =
            ctrl_new[lcc_pkg::LCC_SYNC_LIM_LSB +: lcc_pkg::LCC_SYNC_LIM_W];
      end
      if (wr_take && hit_ptr) begin
         st_next.cur_ptr = ptr_new[PTR_W-1:0];
      end
   end

   // State register
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_reg          <= '0;
         st_reg.resp     <= lcc_pkg::LCC_RESP_OKAY;
         st_reg.rx_win   <=
            lcc_pkg::LCC_CTRL_RESET[lcc_pkg::LCC_RX_WIN_LSB +: lcc_pkg::LCC_RX_WIN_W];
         st_reg.sync_lim <=
            lcc_pkg::LCC_CTRL_RESET[lcc_pkg::LCC_SYNC_LIM_LSB +: lcc_pkg::LCC_SYNC_LIM_W];
         st_reg.cur_ptr  <= lcc_pkg::LCC_RXPTR_RESET[PTR_W-1:0];
      end else begin
         st_reg <= st_next;
      end
   end

   // Scan abort action bit; zero writes do nothing
   lcc_action_bit u_scan_abort (
      .clk_in      (clk_in),
      .resetn_in   (resetn_in),
      .set_in      (wr_take & hit_ctrl & avs_byteenable_in[3]
                    & avs_writedata_in[lcc_pkg::LCC_SCAN_ABORT_BIT]),
      .done_in     (scan_done_in),
      .pending_out (scan_pending)
   );
   assign scan_abort_req_out = scan_pending;

   // Single exchange per event under bypass
   assign next_exchange_out = more_data_in & ~st_reg.md_byp;

   // Transmitted sequence numbers
   lcc_bypass_mux #(.W(1)) u_sn_mux (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .sel_sw_in (st_reg.sn_byp),
      .hw_in     (hw_sn_in),
      .sw_in     (desc_sn_in),
      .out_out   (tx_sn_out)
   );
   lcc_bypass_mux #(.W(1)) u_nesn_mux (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .sel_sw_in (st_reg.nesn_byp),
      .hw_in     (hw_nesn_in),
      .sw_in     (desc_nesn_in),
      .out_out   (tx_nesn_out)
   );

   // Received sequence errors suppressed under bypass
   assign rx_sn_err_out   = rx_sn_err_in & ~st_reg.sn_byp;
   assign rx_nesn_err_out = rx_nesn_err_in & ~st_reg.nesn_byp;

   // Payload cipher off under bypass, MIC kept
   assign payload_encrypt_out = conn_encrypt_enable_in & ~st_reg.crypto_byp;
   assign mic_generate_out    = conn_encrypt_enable_in;

   // Whitening and channel remap enables
   assign whitening_enable_out = ~st_reg.whit_byp;
   assign hop_remap_enable_out = ~st_reg.hop_byp;

   // CRC zeroed on transmit and kept on receive under bypass
   lcc_bypass_mux #(.W(CRC_W)) u_crc_mux (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .sel_sw_in (st_reg.crc_byp),
      .hw_in     (tx_crc_in),
      .sw_in     ({CRC_W{1'b0}}),
      .out_out   (tx_crc_out)
   );
   assign rx_crc_strip_out = ~st_reg.crc_byp;

   // Window offset source, only when initiating
   assign wof_sel_evt = initiator_mode_in & st_reg.winoff_src;
   lcc_bypass_mux #(.W(WOF_W)) u_wof_mux (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .sel_sw_in (wof_sel_evt),
      .hw_in     (buf_winoff_in),
      .sw_in     (evt_winoff_in),
      .out_out   (winoff_out)
   );

   // Rx descriptor pointer source
   lcc_bypass_mux #(.W(PTR_W)) u_ptr_mux (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .sel_sw_in (st_reg.rxptr_src),
      .hw_in     (cs_rx_ptr_in),
      .sw_in     (st_reg.cur_ptr),
      .out_out   (rx_ptr_out)
   );

   // Drop errored advertising packets when filtering
   assign rx_pkt_report_out = rx_pkt_done_in
                              & ~(st_reg.adv_filt & rx_adv_chan_in & rx_pkt_err_in);

   // Coexistence pulse gate
   assign coex_sync_out = coex_sync_in & st_reg.coex_en;

   // Static settings
   assign core_prefetch_enable_out  = st_reg.prefetch;
   assign default_rx_window_out     = st_reg.rx_win;
   assign sync_word_error_limit_out = st_reg.sync_lim;
endmodule
`default_nettype wire

/* testbench/lcc_core_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// Port-level checks for the control register block
module lcc_core_monitor #(
   parameter int WOF_W = 16,
   parameter int CRC_W = 24
) (
   input wire logic             clk_in,
   input wire logic             resetn_in,
   input wire logic [31:0]      avs_address_in,
   input wire logic             avs_read_in,
   input wire logic             avs_write_in,
   input wire logic [31:0]      avs_writedata_in,
   input wire logic [3:0]       avs_byteenable_in,
   input wire logic [31:0]      avs_readdata_out,
   input wire logic [1:0]       avs_response_out,
   input wire logic             avs_waitrequest_out,
   input wire logic             scan_done_in,
   input wire logic             scan_abort_req_out,
   input wire logic             more_data_in,
   input wire logic             next_exchange_out,
   input wire logic             rx_sn_err_in,
   input wire logic             rx_nesn_err_in,
   input wire logic             rx_sn_err_out,
   input wire logic             rx_nesn_err_out,
   input wire logic             conn_encrypt_enable_in,
   input wire logic             payload_encrypt_out,
   input wire logic             mic_generate_out,
   input wire logic [CRC_W-1:0] tx_crc_in,
   input wire logic [CRC_W-1:0] tx_crc_out,
   input wire logic             rx_crc_strip_out,
   input wire logic             initiator_mode_in,
   input wire logic [WOF_W-1:0] buf_winoff_in,
   input wire logic [WOF_W-1:0] winoff_out,
   input wire logic             rx_pkt_done_in,
   input wire logic             rx_adv_chan_in,
   input wire logic             rx_pkt_err_in,
   input wire logic             rx_pkt_report_out,
   input wire logic             coex_sync_in,
   input wire logic             coex_sync_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // Scan abort request life cycle
   property p_scan_set;
      $rose(scan_abort_req_out) |-> $past(avs_write_in && !avs_waitrequest_out
         && avs_writedata_in[24] && avs_byteenable_in[3]
         && avs_address_in == lcc_pkg::LCC_CTRL_ADDR);
   endproperty
   a_scan_set: assert property (p_scan_set)
      else $error("scan abort rose without a write of one");
   property p_scan_hold;
      scan_abort_req_out && !scan_done_in |=> scan_abort_req_out;
   endproperty
   a_scan_hold: assert property (p_scan_hold)
      else $error("scan abort dropped before completion");
   property p_scan_clear;
      scan_abort_req_out && scan_done_in && !avs_write_in |=> !scan_abort_req_out;
   endproperty
   a_scan_clear: assert property (p_scan_clear)
      else $error("scan abort stayed after completion");
   // Reserved control bits read zero
   property p_ctrl_rsv;
      avs_read_in && !avs_waitrequest_out && avs_address_in == lcc_pkg::LCC_CTRL_ADDR
         |-> (avs_readdata_out & 32'hfe80_e008) == 32'h0
         && avs_response_out == lcc_pkg::LCC_RESP_OKAY;
   endproperty
   a_ctrl_rsv: assert property (p_ctrl_rsv)
      else $error("reserved control bits not zero");
   // Gating outputs never invent activity; MIC always made when encryption is enabled
   property p_md;
      next_exchange_out |-> more_data_in;
   endproperty
   a_md: assert property (p_md)
      else $error("extra exchange without more data");
   property p_seq_err;
      (rx_sn_err_out || rx_nesn_err_out) |-> (rx_sn_err_out <= rx_sn_err_in)
         && (rx_nesn_err_out <= rx_nesn_err_in);
   endproperty
   a_seq_err: assert property (p_seq_err)
      else $error("sequence error reported without cause");
   property p_crypto;
      payload_encrypt_out |-> conn_encrypt_enable_in && mic_generate_out;
   endproperty
   a_crypto: assert property (p_crypto)
      else $error("payload encrypted without enable");
   property p_mic;
      conn_encrypt_enable_in |-> mic_generate_out;
   endproperty
   a_mic: assert property (p_mic)
      else $error("integrity code not generated");
   // Registered CRC follows the bypass seen one edge earlier
   property p_crc;
      $past(resetn_in) |->
         tx_crc_out == ($past(rx_crc_strip_out) ? $past(tx_crc_in) : {CRC_W{1'b0}});
   endproperty
   a_crc: assert property (p_crc)
      else $error("transmit crc value wrong");
   property p_winoff;
      $past(resetn_in) && !$past(initiator_mode_in) |-> winoff_out == $past(buf_winoff_in);
   endproperty
   a_winoff: assert property (p_winoff)
      else $error("window offset not from buffer outside initiator");
   property p_adv;
      rx_pkt_done_in && !(rx_adv_chan_in && rx_pkt_err_in) |-> rx_pkt_report_out;
   endproperty
   a_adv: assert property (p_adv)
      else $error("good packet not reported");
   property p_coex;
      coex_sync_out |-> coex_sync_in;
   endproperty
   a_coex: assert property (p_coex)
      else $error("coexistence pulse without source");
endmodule
`default_nettype wire

/* testbench/radio_link_core_control_test.sv */
`timescale 1ns/1ns
`default_nettype none
module radio_link_core_control_test;
   localparam int          PTR_W = 15;
   localparam int          WOF_W = 16;
   localparam int          CRC_W = 24;
   localparam logic [31:0] CTRL  = lcc_pkg::LCC_CTRL_ADDR;
   localparam logic [31:0] PTR   = lcc_pkg::LCC_RXPTR_ADDR;
   localparam logic [31:0] BAD   = 32'h4000_0080;
   localparam logic [1:0]  OKAY  = lcc_pkg::LCC_RESP_OKAY;
   localparam logic [14:0] PVAL  = 15'h1357;
   logic             clk_in = 1'b0, resetn_in = 1'b0;
   logic [31:0]      avs_address_in = 32'h0, avs_writedata_in = 32'h0, avs_readdata_out;
   logic             avs_read_in = 1'b0, avs_write_in = 1'b0, avs_waitrequest_out;
   logic [3:0]       avs_byteenable_in = 4'hf;
   logic [1:0]       avs_response_out;
   logic             scan_done_in = 1'b0, more_data_in = 1'b1, conn_encrypt_enable_in = 1'b1;
   logic             hw_sn_in = 1'b0, desc_sn_in = 1'b1, hw_nesn_in = 1'b1, desc_nesn_in = 1'b0;
   logic             rx_sn_err_in = 1'b1, rx_nesn_err_in = 1'b1, initiator_mode_in = 1'b1;
   logic             rx_pkt_done_in = 1'b1, rx_adv_chan_in = 1'b1, rx_pkt_err_in = 1'b1;
   logic             coex_sync_in = 1'b1;
   logic [CRC_W-1:0] tx_crc_in = 24'h5a_c3a5, tx_crc_out;
   logic [WOF_W-1:0] buf_winoff_in = 16'h1234, evt_winoff_in = 16'hbeef, winoff_out;
   logic [PTR_W-1:0] cs_rx_ptr_in = 15'h0abc, rx_ptr_out;
   logic             scan_abort_req_out, next_exchange_out, tx_sn_out, tx_nesn_out;
   logic             rx_sn_err_out, rx_nesn_err_out, payload_encrypt_out, mic_generate_out;
   logic             whitening_enable_out, hop_remap_enable_out, rx_crc_strip_out;
   logic             rx_pkt_report_out, coex_sync_out, core_prefetch_enable_out;
   logic [3:0]       default_rx_window_out;
   logic [2:0]       sync_word_error_limit_out;
   int               err_total = 0, n_checks = 0;
   // Free-running core clock
   always #4 clk_in = ~clk_in;
   lcc_core #(.PTR_W(PTR_W), .WOF_W(WOF_W), .CRC_W(CRC_W)) lcc_core_inst (.*);
   // Compare and count
   task automatic check(input string name, input logic [33:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One Avalon transfer; r is {response, readdata}
   task automatic bus(input logic wr, input logic [31:0] a, d, input logic [3:0] be,
                      output logic [33:0] r);
      @(posedge clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_byteenable_in <= be;
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      // Hold the request until waitrequest is seen low; the watchdog ends a hang
      do begin
         @(posedge clk_in);
      end while (avs_waitrequest_out !== 1'b0);
      r = {avs_response_out, avs_readdata_out};
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask
   // Let one more edge land, then look mid-cycle
   task automatic settle();
      @(posedge clk_in);
      @(negedge clk_in);
   endtask
   task automatic t_reset_values();
      logic [33:0] r;
      bus(1'b0, CTRL, 32'h0, 4'hf, r);
      check("ctrl reset", r, {OKAY, lcc_pkg::LCC_CTRL_RESET});
      check("whitening", whitening_enable_out, 1'b1);
      check("hop remap", hop_remap_enable_out, 1'b1);
      check("crc strip", rx_crc_strip_out, 1'b1);
   endtask
   task automatic t_decode();
      logic [33:0] r;
      bus(1'b1, BAD, 32'hffff_ffff, 4'hf, r);
      bus(1'b0, BAD, 32'h0, 4'hf, r);
      check("unmapped read", r, {lcc_pkg::LCC_RESP_DECERR, 32'h0});
      bus(1'b0, CTRL, 32'h0, 4'hf, r);
      check("ctrl intact", r, {OKAY, 32'h0});
      bus(1'b1, PTR, 32'hffff_9357, 4'hf, r);
      bus(1'b0, PTR, 32'h0, 4'hf, r);
      check("ptr readback", r, {OKAY, 17'h0, PVAL});
   endtask
   // Every field but scan abort set, or every field clear with a legal window
   task automatic t_fields(input logic on);
      logic [33:0] r;
      bus(1'b1, CTRL, on ? 32'hfeff_ffff : 32'h0000_00a0, 4'hf, r);
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      check("next exchange", next_exchange_out, !on);
      check("tx sn", tx_sn_out, on ? desc_sn_in : hw_sn_in);
      check("tx nesn", tx_nesn_out, on ? desc_nesn_in : hw_nesn_in);
      check("sn err", rx_sn_err_out, !on);
      check("nesn err", rx_nesn_err_out, !on);
      check("payload enc", payload_encrypt_out, !on);
      check("mic", mic_generate_out, 1'b1);
      check("whitening", whitening_enable_out, !on);
      check("tx crc", tx_crc_out, on ? {CRC_W{1'b0}} : tx_crc_in);
      check("crc strip", rx_crc_strip_out, !on);
      check("hop remap", hop_remap_enable_out, !on);
      check("winoff", winoff_out, on ? evt_winoff_in : buf_winoff_in);
      check("rx ptr", rx_ptr_out, on ? PVAL : cs_rx_ptr_in);
      check("adv report", rx_pkt_report_out, !on);
      check("coex pulse", coex_sync_out, on);
      check("prefetch", core_prefetch_enable_out, on);
      check("rx window", default_rx_window_out, on ? 4'hf : 4'ha);
      check("sync limit", sync_word_error_limit_out, on ? 3'h7 : 3'h0);
      bus(1'b0, CTRL, 32'h0, 4'hf, r);
      check("ctrl readback", r, {OKAY, on ? 32'h007f_1ff7 : 32'h0000_00a0});
      @(posedge clk_in);
      initiator_mode_in <= 1'b0;
      rx_adv_chan_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      check("winoff responder", winoff_out, buf_winoff_in);
      check("data chan report", rx_pkt_report_out, 1'b1);
      @(posedge clk_in);
      initiator_mode_in <= 1'b1;
      rx_adv_chan_in <= 1'b1;
   endtask
   task automatic t_scan();
      logic [33:0] r;
      bus(1'b1, CTRL, 32'h0100_00a0, 4'h7, r);
      settle();
      check("abort lane off", scan_abort_req_out, 1'b0);
      bus(1'b1, CTRL, 32'h0100_00a0, 4'hf, r);
      settle();
      check("abort req", scan_abort_req_out, 1'b1);
      bus(1'b0, CTRL, 32'h0, 4'hf, r);
      check("abort read", r, {OKAY, 32'h0100_00a0});
      bus(1'b1, CTRL, 32'h0000_00a0, 4'hf, r);
      settle();
      check("abort zero write", scan_abort_req_out, 1'b1);
      @(posedge clk_in);
      scan_done_in <= 1'b1;
      @(posedge clk_in);
      scan_done_in <= 1'b0;
      @(negedge clk_in);
      check("abort done", scan_abort_req_out, 1'b0);
      bus(1'b0, CTRL, 32'h0, 4'hf, r);
      check("abort cleared", r, {OKAY, 32'h0000_00a0});
   endtask
   // Counts, verdict and end of run
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge clk_in);
      resetn_in <= 1'b1;
      t_reset_values();
      t_decode();
      t_fields(1'b1);
      t_fields(1'b0);
      t_scan();
      give_verdict();
   end
   // Hang guard
   initial begin
      repeat (5000) @(posedge clk_in);
      err_total++;
      give_verdict();
   end
endmodule
bind lcc_core lcc_core_monitor #(.WOF_W(WOF_W), .CRC_W(CRC_W)) lcc_core_monitor_inst (.*);
`default_nettype wire
